/* File: hw/drs_pkg.sv */
package drs_pkg;
	localparam int NRES = 16;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam logic [7:0] A_CTRL0 = 8'h00;
	localparam logic [7:0] A_OWN = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_SPC = 8'h0C;
	localparam logic [7:0] A_SMSR = 8'h10;
	localparam logic [7:0] A_VEC = 8'h14;
	localparam logic [7:0] A_RESUME = 8'h18;
	localparam logic [7:0] A_ISTAT = 8'h1C;
	localparam logic [7:0] A_IMASK = 8'h20;
	localparam int EXT_EN_BIT = 31;
	localparam int SHARE_BIT = 31;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] RST_VEC = 32'h0000_0000;
	localparam logic [31:0] DBG_INT_EN_MASK = 32'h0000_0200;
	localparam int NIRQ = 3;
	localparam int IRQ_ENTER = 0;
	localparam int IRQ_SWINT = 1;
	localparam int IRQ_REFUSE = 2;
	typedef enum logic [1:0] {ST_IDLE, ST_SW_EXC, ST_HALT} drs_state_t;
endpackage

/* File: hw/drs_ev_if.sv */
interface drs_ev_if #(
	parameter int NRES = drs_pkg::NRES
);
	logic [NRES:0]   evt;
	logic [NRES-1:0] en;
	logic [NRES-1:0] hw_own;
	logic            external_debug_enable;
	logic            resource_sharing_select;
	logic [NRES:0]   hw_evt;
	logic [NRES:0]   sw_evt;
	logic            dbg_int_en;
	logic            core_saved;
	logic            resume;
	logic            int_req;
	logic            enter;
	logic            halted;
	modport ctl (output evt, en, hw_own, external_debug_enable, resource_sharing_select,
		dbg_int_en, core_saved, resume, input hw_evt, sw_evt, int_req, enter, halted);
	modport cls (input evt, en, hw_own, external_debug_enable, resource_sharing_select,
		output hw_evt, sw_evt);
	modport seq (input hw_evt, sw_evt, dbg_int_en, core_saved, resume,
		output int_req, enter, halted);
endinterface

/* File: hw/drs_classify.sv */
module drs_classify #(
	parameter int NRES = drs_pkg::NRES
) (
	// Event classification
	drs_ev_if.cls ev
);
	logic [NRES:0] act;
	logic [NRES:0] hwm;

	always_comb begin
		act = ev.evt & {1'b1, ev.en};
		if (!ev.external_debug_enable) begin
			hwm = '0;
		end else if (ev.resource_sharing_select) begin
			hwm = {1'b1, ev.hw_own};
		end else begin
			hwm = '1;
		end
		ev.hw_evt = act & hwm;
		ev.sw_evt = act & ~hwm;
	end
endmodule

/* File: hw/drs_entry_seq.sv */
module drs_entry_seq (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Sequencing handshake
	drs_ev_if.seq    ev
);
	import drs_pkg::*;
	drs_state_t state;
	drs_state_t next_state;
	logic       pend;
	logic       next_pend;
	logic       hw;
	logic       sw;

	assign hw = |ev.hw_evt;
	assign sw = |ev.sw_evt;
	assign ev.int_req = (state == ST_SW_EXC);
	assign ev.halted = (state == ST_HALT);

	always_comb begin
		next_state = state;
		next_pend = pend;
		case (state)
			ST_IDLE: begin
				next_pend = 1'b0;
				if (hw && sw && ev.dbg_int_en) begin
					next_state = ST_SW_EXC;
					next_pend = 1'b1;
				end else if (hw) begin
					next_state = ST_HALT;
				end else if (sw && ev.dbg_int_en) begin
					next_state = ST_SW_EXC;
				end
			end
			ST_SW_EXC: begin
				next_pend = pend | hw;
				if (ev.core_saved) begin
					next_state = (pend || hw) ? ST_HALT : ST_IDLE;
				end
			end
			default: begin
				if (ev.resume) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= ST_IDLE;
			pend <= 1'b0;
			ev.enter <= 1'b0;
		end else begin
			state <= next_state;
			pend <= next_pend;
			ev.enter <= (next_state == ST_HALT) && (state != ST_HALT);
		end
	end

	a_sw_first: assert property (
		@(posedge clk) disable iff (!rstn)
		state == ST_IDLE && hw && sw && ev.dbg_int_en |=> ev.int_req && !ev.halted)
		else $error("Software event not taken ahead of debug entry.");

	a_saved_enter: assert property (
		@(posedge clk) disable iff (!rstn)
		state == ST_SW_EXC && pend && ev.core_saved |=> ev.halted && ev.enter ##1 !ev.enter)
		else $error("Debug entry did not follow the saved exception.");
endmodule

/* File: hw/drs_top.sv */
module drs_top #(
	parameter int NRES = drs_pkg::NRES
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// Software register port
	input  wire logic [drs_pkg::AW-1:0] sw_addr,
	input  wire logic [drs_pkg::DW-1:0] sw_wdata,
	input  wire logic                   sw_wr,
	input  wire logic                   sw_rd,
	output logic      [drs_pkg::DW-1:0] sw_rdata,
	// Debugger register port
	input  wire logic [drs_pkg::AW-1:0] dbg_addr,
	input  wire logic [drs_pkg::DW-1:0] dbg_wdata,
	input  wire logic                   dbg_wr,
	input  wire logic                   dbg_rd,
	output logic      [drs_pkg::DW-1:0] dbg_rdata,
	// Debug resources
	input  wire logic [NRES-1:0]        res_evt,
	input  wire logic                   uncond_evt,
	// Core exception handshake
	input  wire logic                   dbg_int_en,
	input  wire logic                   core_saved,
	input  wire logic [drs_pkg::DW-1:0] core_pc,
	input  wire logic [drs_pkg::DW-1:0] core_state,
	output logic                        dbg_int_req,
	output logic      [drs_pkg::DW-1:0] pc_target,
	output logic      [drs_pkg::DW-1:0] state_target,
	output logic                        debug_mode,
	output logic                        debug_entry,
	// Interrupt
	output logic                        irq
);
	import drs_pkg::*;

	drs_ev_if #(.NRES(NRES)) ev ();

	logic [NRES-1:0] en;
	logic            external_debug_enable;
	logic            resource_sharing_select;
	logic [NRES-1:0] hw_own;
	logic [NRES:0]   stat;
	logic [DW-1:0]   save_pc;
	logic [DW-1:0]   save_state;
	logic [DW-1:0]   vec;
	logic [NIRQ-1:0] istat;
	logic [NIRQ-1:0] imask;
	logic            sharing;
	logic [NRES:0]   hidem;
	logic [NRES-1:0] swlock;
	logic [NRES:0]   stat_set;
	logic [NRES:0]   stat_clr;
	logic [NIRQ-1:0] irq_set;
	logic [NIRQ-1:0] irq_clr;
	logic            capture;
	logic            refuse;
	logic            sw_ctrl;
	logic            sw_own;
	logic            sw_stat;
	logic            dbg_ctrl;
	logic            dbg_own;
	logic            dbg_stat;

	function automatic logic hit(
		input logic          stb,
		input logic [AW-1:0] addr,
		input logic [AW-1:0] reg_addr
	);
		return stb && (addr == reg_addr);
	endfunction

	function automatic logic [DW-1:0] rd_word(
		input logic [AW-1:0] addr,
		input logic [NRES:0] hide
	);
		logic [DW-1:0] w;
		w = RST_WORD;
		if (addr == A_CTRL0) begin
			w[NRES-1:0] = en;
			w[EXT_EN_BIT] = external_debug_enable;
		end else if (addr == A_OWN) begin
			w[NRES-1:0] = hw_own;
			w[SHARE_BIT] = resource_sharing_select;
		end else if (addr == A_STAT) begin
			w[NRES:0] = stat & ~hide;
		end else if (addr == A_SPC) begin
			w = save_pc;
		end else if (addr == A_SMSR) begin
			w = save_state;
		end else if (addr == A_VEC) begin
			w = vec;
		end else if (addr == A_RESUME) begin
			w[0] = ev.halted;
		end else if (addr == A_ISTAT) begin
			w[NIRQ-1:0] = istat;
		end else if (addr == A_IMASK) begin
			w[NIRQ-1:0] = imask;
		end
		return w;
	endfunction

	assign sharing = external_debug_enable && resource_sharing_select;
	assign swlock = sharing ? hw_own : '0;
	assign hidem = sharing ? {1'b1, hw_own} : '0;

	assign sw_ctrl = hit(sw_wr, sw_addr, A_CTRL0);
	assign sw_own = hit(sw_wr, sw_addr, A_OWN);
	assign sw_stat = hit(sw_wr, sw_addr, A_STAT);
	assign dbg_ctrl = hit(dbg_wr, dbg_addr, A_CTRL0);
	assign dbg_own = hit(dbg_wr, dbg_addr, A_OWN);
	assign dbg_stat = hit(dbg_wr, dbg_addr, A_STAT);

	assign ev.evt = {uncond_evt, res_evt};
	assign ev.en = en;
	assign ev.hw_own = hw_own;
	assign ev.external_debug_enable = external_debug_enable;
	assign ev.resource_sharing_select = resource_sharing_select;
	assign ev.dbg_int_en = dbg_int_en;
	assign ev.core_saved = core_saved;
	assign ev.resume = hit(dbg_wr, dbg_addr, A_RESUME) && dbg_wdata[0];

	drs_classify #(
		.NRES(NRES)
	) u_classify (
		.ev(ev)
	);

	drs_entry_seq u_seq (
		.clk (clk),
		.rstn(rstn),
		.ev  (ev)
	);

	assign capture = ev.int_req && core_saved;
	assign dbg_int_req = ev.int_req;
	assign debug_mode = ev.halted;
	assign debug_entry = ev.enter;
	assign pc_target = vec;
	assign irq = |(istat & imask);

	assign stat_set = ev.hw_evt | ev.sw_evt;
	assign stat_clr = (dbg_stat ? dbg_wdata[NRES:0] : '0)
		| (sw_stat ? (sw_wdata[NRES:0] & ~hidem) : '0);

	assign refuse = sw_own
		|| (sw_ctrl && ((sw_wdata[NRES-1:0] ^ en) & swlock) != '0)
		|| (sw_stat && (sw_wdata[NRES:0] & hidem) != '0);

	assign irq_set = {refuse, capture && !ev.halted, ev.enter};
	assign irq_clr = (hit(sw_wr, sw_addr, A_ISTAT) ? sw_wdata[NIRQ-1:0] : '0)
		| (hit(dbg_wr, dbg_addr, A_ISTAT) ? dbg_wdata[NIRQ-1:0] : '0);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sw_rdata <= RST_WORD;
		end else if (sw_rd) begin
			sw_rdata <= rd_word(sw_addr, hidem);
		end else begin
			sw_rdata <= RST_WORD;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			dbg_rdata <= RST_WORD;
		end else if (dbg_rd) begin
			dbg_rdata <= rd_word(dbg_addr, '0);
		end else begin
			dbg_rdata <= RST_WORD;
		end
	end

	// Control word: the debugger wins a same-cycle write from software.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			en <= '0;
			external_debug_enable <= 1'b0;
		end else if (dbg_ctrl) begin
			en <= dbg_wdata[NRES-1:0];
			external_debug_enable <= dbg_wdata[EXT_EN_BIT];
		end else if (sw_ctrl) begin
			en <= (en & swlock) | (sw_wdata[NRES-1:0] & ~swlock);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			hw_own <= '0;
			resource_sharing_select <= 1'b0;
		end else if (dbg_own) begin
			hw_own <= dbg_wdata[NRES-1:0];
			resource_sharing_select <= dbg_wdata[SHARE_BIT];
		end
	end

	// Status flags: a new event wins over a clear in the same cycle.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			stat <= '0;
		end else begin
			stat <= (stat & ~stat_clr) | stat_set;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			save_pc <= RST_WORD;
			save_state <= RST_WORD;
			state_target <= RST_WORD;
		end else if (capture) begin
			save_pc <= core_pc;
			save_state <= core_state;
			state_target <= core_state & ~DBG_INT_EN_MASK;
		end else begin
			if (hit(dbg_wr, dbg_addr, A_SPC)) begin
				save_pc <= dbg_wdata;
			end else if (hit(sw_wr, sw_addr, A_SPC)) begin
				save_pc <= sw_wdata;
			end
			if (hit(dbg_wr, dbg_addr, A_SMSR)) begin
				save_state <= dbg_wdata;
			end else if (hit(sw_wr, sw_addr, A_SMSR)) begin
				save_state <= sw_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			vec <= RST_VEC;
		end else if (hit(dbg_wr, dbg_addr, A_VEC)) begin
			vec <= dbg_wdata;
		end else if (hit(sw_wr, sw_addr, A_VEC)) begin
			vec <= sw_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			istat <= '0;
		end else begin
			istat <= (istat & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			imask <= '0;
		end else if (hit(dbg_wr, dbg_addr, A_IMASK)) begin
			imask <= dbg_wdata[NIRQ-1:0];
		end else if (hit(sw_wr, sw_addr, A_IMASK)) begin
			imask <= sw_wdata[NIRQ-1:0];
		end
	end

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (!rstn);

	a_own_readonly: assert property (
		sw_own && !dbg_own |=> $stable(hw_own) && $stable(resource_sharing_select))
		else $error("Software write changed the ownership register.");

	a_refuse_flag: assert property (
		sw_own |=> istat[IRQ_REFUSE])
		else $error("Refused ownership write did not set its flag.");

	a_hw_enter: assert property (
		!ev.halted && !ev.int_req && (|ev.hw_evt) && !((|ev.sw_evt) && dbg_int_en)
		|=> debug_mode && debug_entry)
		else $error("Hardware-owned event did not enter debug mode.");

	a_halt_hold: assert property (
		debug_mode && !ev.resume |=> debug_mode)
		else $error("Debug mode was left without a resume write.");

	a_resume_exit: assert property (
		ev.resume && ev.halted |=> !debug_mode)
		else $error("Resume write did not leave debug mode.");

	a_sw_ctrl_guard: assert property (
		sw_ctrl && sharing && !dbg_ctrl
		|=> ((en ^ $past(en)) & $past(hw_own)) == '0)
		else $error("Software changed a hardware-owned enable.");

	a_ext_en_guard: assert property (
		sw_ctrl && !dbg_ctrl |=> $stable(external_debug_enable))
		else $error("Software changed the external debug enable.");

	a_stat_guard: assert property (
		sw_stat && !dbg_stat && sharing
		|=> (($past(stat) & ~stat) & {1'b1, $past(hw_own)}) == '0)
		else $error("Software cleared a hardware-owned status bit.");

	a_sw_hide: assert property (
		sw_rd && sw_addr == A_STAT && sharing
		|=> (sw_rdata[NRES:0] & {1'b1, $past(hw_own)}) == '0)
		else $error("Software read saw a hardware-owned status bit.");

	a_sw_rd_zero: assert property (
		!sw_rd |=> sw_rdata == '0)
		else $error("Software read data stood beyond its cycle.");

	a_dbg_full: assert property (
		dbg_rd && dbg_addr == A_STAT |=> dbg_rdata[NRES:0] == $past(stat))
		else $error("Debugger read of status was masked.");

	a_save_pair: assert property (
		capture |=> save_pc == $past(core_pc) && save_state == $past(core_state))
		else $error("Save pair did not capture the core state.");

	a_state_target: assert property (
		capture |=> state_target == ($past(core_state) & ~DBG_INT_EN_MASK))
		else $error("Handler machine state was not loaded.");

	a_uncond_set: assert property (
		uncond_evt |=> stat[NRES])
		else $error("Unconditional event flag was not set.");

	a_sw_int: assert property (
		!ev.halted && !ev.int_req && (|ev.sw_evt) && !(|ev.hw_evt) && dbg_int_en
		|=> dbg_int_req && !debug_mode ##1 !debug_entry)
		else $error("Software event was not delivered as an interrupt.");

	a_entry_flag: assert property (
		debug_entry |=> istat[IRQ_ENTER])
		else $error("Debug entry did not set its status flag.");

	a_irq_level: assert property (
		debug_entry && imask[IRQ_ENTER] && !sw_wr && !dbg_wr |=> irq)
		else $error("Unmasked status bit did not raise the interrupt.");
endmodule

/* File: verif/drs_core_model.sv */
module drs_core_model (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// Exception handshake
	input  wire logic                   slow,
	input  wire logic                   dbg_int_req,
	output logic                        core_saved,
	output logic      [drs_pkg::DW-1:0] core_pc,
	output logic      [drs_pkg::DW-1:0] core_state
);
	timeunit 1ns;
	timeprecision 1ps;
	import drs_pkg::*;
	int wait_n;
	// Outside the save cycle the state lines toggle so stale values never look valid.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wait_n <= 0;
			core_saved <= 1'b0;
			core_pc <= 32'h0000_0000;
			core_state <= 32'h0000_0000;
		end else begin
			core_saved <= 1'b0;
			core_pc <= ~core_pc;
			core_state <= ~core_state;
			if (dbg_int_req && !core_saved) begin
				wait_n <= wait_n + 1;
				if (wait_n == (slow ? 6 : 1)) begin
					core_saved <= 1'b1;
					core_pc <= 32'h0000_4A50;
					core_state <= 32'h0000_8200;
					wait_n <= 0;
				end
			end
		end
	end
endmodule

/* File: verif/test_drs_top.sv */
module test_drs_top;
	timeunit 1ns;
	timeprecision 1ps;
	import drs_pkg::*;
	logic            clk;
	logic            rstn;
	logic [AW-1:0]   sw_addr;
	logic [DW-1:0]   sw_wdata;
	logic            sw_wr;
	logic            sw_rd;
	logic [DW-1:0]   sw_rdata;
	logic [AW-1:0]   dbg_addr;
	logic [DW-1:0]   dbg_wdata;
	logic            dbg_wr;
	logic            dbg_rd;
	logic [DW-1:0]   dbg_rdata;
	logic [NRES-1:0] res_evt;
	logic            uncond_evt;
	logic            dbg_int_en;
	logic            core_saved;
	logic [DW-1:0]   core_pc;
	logic [DW-1:0]   core_state;
	logic            dbg_int_req;
	logic [DW-1:0]   pc_target;
	logic [DW-1:0]   state_target;
	logic            debug_mode;
	logic            debug_entry;
	logic            irq;
	logic            slow;
	logic            seen;
	logic [DW-1:0]   q;
	int              n_fail;
	int              cmp_count;
	int              cycles;
	drs_top u_drs_top (.clk(clk), .rstn(rstn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dbg_addr(dbg_addr),
		.dbg_wdata(dbg_wdata), .dbg_wr(dbg_wr), .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata),
		.res_evt(res_evt), .uncond_evt(uncond_evt), .dbg_int_en(dbg_int_en),
		.core_saved(core_saved), .core_pc(core_pc), .core_state(core_state),
		.dbg_int_req(dbg_int_req), .pc_target(pc_target), .state_target(state_target),
		.debug_mode(debug_mode), .debug_entry(debug_entry), .irq(irq));
	drs_core_model u_drs_core_model (.clk(clk), .rstn(rstn), .slow(slow),
		.dbg_int_req(dbg_int_req), .core_saved(core_saved), .core_pc(core_pc),
		.core_state(core_state));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic acc(input logic dbg, input logic wr, input logic [AW-1:0] a,
		input logic [DW-1:0] d);
		@(posedge clk);
		if (dbg) begin
			dbg_addr <= a;
			dbg_wdata <= d;
			dbg_wr <= wr;
			dbg_rd <= !wr;
		end else begin
			sw_addr <= a;
			sw_wdata <= d;
			sw_wr <= wr;
			sw_rd <= !wr;
		end
		@(posedge clk);
		dbg_wr <= 1'b0;
		dbg_rd <= 1'b0;
		sw_wr <= 1'b0;
		sw_rd <= 1'b0;
		#1;
		q = dbg ? dbg_rdata : sw_rdata;
	endtask
	task automatic rd_chk(input logic dbg, input logic [AW-1:0] a, input logic [DW-1:0] e,
		input string name);
		acc(dbg, 1'b0, a, 32'h0000_0000);
		chk(name, e, q);
	endtask
	task automatic pulse(input logic [NRES-1:0] r, input logic u);
		@(posedge clk);
		res_evt <= r;
		uncond_evt <= u;
		@(posedge clk);
		res_evt <= '0;
		uncond_evt <= 1'b0;
	endtask
	task automatic wait_entry;
		int i;
		seen = 1'b0;
		#1;
		for (i = 0; i < 40 && debug_entry !== 1'b1; i++) begin
			@(posedge clk);
			#1;
			if (dbg_int_req === 1'b1 && debug_mode !== 1'b1) seen = 1'b1;
		end
	endtask
	initial begin
		rstn = 1'b0;
		{sw_addr, sw_wdata, sw_wr, sw_rd, dbg_addr, dbg_wdata, dbg_wr, dbg_rd} = '0;
		res_evt = '0;
		uncond_evt = 1'b0;
		dbg_int_en = 1'b0;
		slow = 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(1, A_CTRL0, 32'h0000_0000, "ctrl0 reset");
		rd_chk(1, A_OWN, 32'h0000_0000, "own reset");
		rd_chk(1, 8'h40, 32'h0000_0000, "unmapped");
		acc(1, 1, A_VEC, 32'h0000_1000);
		acc(1, 1, A_OWN, 32'h8000_0008);
		acc(1, 1, A_CTRL0, 32'h8000_0018);
		rd_chk(1, A_OWN, 32'h8000_0008, "own dbg");
		rd_chk(1, A_CTRL0, 32'h8000_0018, "ctrl0 dbg");
		acc(0, 1, A_OWN, 32'h0000_FFFF);
		rd_chk(1, A_OWN, 32'h8000_0008, "own after sw");
		acc(0, 1, A_CTRL0, 32'h0000_0000);
		rd_chk(1, A_CTRL0, 32'h8000_0008, "ctrl0 after sw");
		rd_chk(1, A_ISTAT, 32'h0000_0004, "refused flag");
		acc(1, 1, A_IMASK, 32'h0000_0007);
		chk("irq set", 32'h1, {31'h0, irq});
		acc(0, 1, A_ISTAT, 32'h0000_0004);
		chk("irq clear", 32'h0, {31'h0, irq});
		acc(1, 0, A_CTRL0, 32'h0000_0000);
		acc(1, 1, A_CTRL0, q | 32'h0000_0010);
		@(posedge clk);
		slow <= 1'b1;
		dbg_int_en <= 1'b1;
		pulse(16'h0018, 1'b0);
		wait_entry();
		chk("request first", 32'h1, {31'h0, seen});
		chk("entry pulse", 32'h1, {31'h0, debug_entry});
		chk("debug mode", 32'h1, {31'h0, debug_mode});
		chk("pc target", 32'h0000_1000, pc_target);
		chk("state target", 32'h0000_8000, state_target);
		rd_chk(1, A_SPC, 32'h0000_4A50, "saved pc");
		rd_chk(1, A_SMSR, 32'h0000_8200, "saved msr");
		pulse(16'h0000, 1'b1);
		rd_chk(1, A_STAT, 32'h0001_0018, "status dbg");
		rd_chk(0, A_STAT, 32'h0000_0010, "status sw");
		acc(0, 1, A_STAT, 32'hFFFF_FFFF);
		rd_chk(1, A_STAT, 32'h0001_0008, "status kept");
		acc(1, 1, A_RESUME, 32'h0000_0001);
		chk("resumed", 32'h0, {31'h0, debug_mode});
		acc(1, 1, A_STAT, 32'hFFFF_FFFF);
		acc(1, 1, A_ISTAT, 32'h0000_0007);
		@(posedge clk);
		slow <= 1'b0;
		pulse(16'h0010, 1'b0);
		wait_entry();
		chk("sw interrupt", 32'h1, {31'h0, seen});
		chk("no halt", 32'h0, {31'h0, debug_mode});
		rd_chk(1, A_ISTAT, 32'h0000_0002, "delivered");
		@(posedge clk);
		dbg_int_en <= 1'b0;
		pulse(16'h0008, 1'b0);
		wait_entry();
		chk("hw entry pulse", 32'h1, {31'h0, debug_entry});
		chk("hw halt", 32'h1, {31'h0, debug_mode});
		complete_run();
	end
endmodule
